// file: src/fbl_defs.svh
// Constants for the flash boot lock protection block.
`ifndef FBL_DEFS_SVH
`define FBL_DEFS_SVH
`define FBL_PTR_W 24
`define FBL_WADDR_W 23
`define FBL_PAGE_WORD_BITS 7
`define FBL_BOOT_START_DEF 23'h7F000
`define FBL_APP_RESET_ADDR 23'h000000
`define FBL_GUARD_OPEN 2'h3
`define FBL_GUARD_NOWRITE 2'h2
`define FBL_GUARD_LOCKED 2'h0
`define FBL_GUARD_NOREAD 2'h1
`define FBL_EXT_RST 8'h00
`define FBL_PTR_RST 8'h00
`endif

// file: src/fbl_pkg.sv
// Types for the flash boot lock protection block.
`default_nettype none
package fbl_pkg;
   typedef logic [1:0] fbl_guard_t;
   typedef enum logic [1:0] {
      FBL_OP_NONE,
      FBL_OP_LOAD,
      FBL_OP_STORE,
      FBL_OP_GUARD_SET
   } fbl_op_t;
endpackage
`default_nettype wire

// file: src/fbl_guard_check.sv
// Combinational section classification and access decision.
`include "fbl_defs.svh"
`default_nettype none
module fbl_guard_check
   import fbl_pkg::*;
(
   input wire logic [`FBL_WADDR_W-1:0] pc_word,
   input wire logic [`FBL_WADDR_W-1:0] target_word,
   input wire logic [`FBL_WADDR_W-1:0] boot_start,
   input wire fbl_pkg::fbl_guard_t app_guard,
   input wire fbl_pkg::fbl_guard_t loader_guard,
   input wire logic ivt_in_loader,
   output logic exec_in_loader,
   output logic target_in_loader,
   output logic store_ok,
   output logic load_ok,
   output logic irq_ok
);
   function automatic logic write_blocked(input fbl_guard_t g);
      write_blocked = (g == `FBL_GUARD_NOWRITE) || (g == `FBL_GUARD_LOCKED);
   endfunction
   function automatic logic read_blocked(input fbl_guard_t g);
      read_blocked = (g == `FBL_GUARD_LOCKED) || (g == `FBL_GUARD_NOREAD);
   endfunction
   always_comb begin
      exec_in_loader = (pc_word >= boot_start); // see [R21]
      target_in_loader = (target_word >= boot_start);
      // Stores from the application section never program flash.
      store_ok = exec_in_loader; // see [R20]
      if (target_in_loader) begin
         if (write_blocked(loader_guard)) begin
            store_ok = 1'b0; // see [R9]
         end
      end else if (write_blocked(app_guard)) begin
         store_ok = 1'b0; // see [R6] see [R5]
      end
      load_ok = 1'b1; // see [R4]
      if (exec_in_loader && !target_in_loader && read_blocked(app_guard)) begin
         load_ok = 1'b0; // see [R7]
      end
      if (!exec_in_loader && target_in_loader &&
          read_blocked(loader_guard)) begin
         load_ok = 1'b0; // see [R10]
      end
      irq_ok = 1'b1;
      if (ivt_in_loader && !exec_in_loader && read_blocked(app_guard)) begin
         irq_ok = 1'b0; // see [R8]
      end
      if (!ivt_in_loader && exec_in_loader && read_blocked(loader_guard)) begin
         irq_ok = 1'b0; // see [R11]
      end
   end
endmodule
`default_nettype wire

// file: src/fbl_top.sv
// Flash boot lock protection and flash pointer formation.
//
// Overview of operation
// [R1] Application and loader guard fields are kept and set independently.
// [R2] Guard bits only get programmed; only chip erase returns them to one.
// [R3] General write lock never affects store programming.
// [R4] General read/write lock never blocks loads or stores.
// [R5] One means unprogrammed; app field 11 imposes no restriction.
// [R6] App modes 2 and 3 reject stores to the application section.
// [R7] App modes 3 and 4 refuse loader-side loads of application data.
// [R8] App modes 3,4 with vectors in loader mask interrupts in application.
// [R9] Loader modes 2 and 3 reject stores to the loader section.
// [R10] Loader modes 3 and 4 refuse application-side loads of loader data.
// [R11] Loader modes 3,4 with vectors in application mask loader interrupts.
// [R12] Reset vector fuse one starts at zero, zero at loader start.
// [R13] Software has no path to change fuses.
// [R14] Pointer is extension, high byte, low byte from top down.
// [R15] Extension register exists only for program space above 64K bytes.
// [R16] Store word address splits into word-in-page and page number.
// [R17] Software uses the same page for erase and write.
// [R18] Programming captures the pointer so later changes do not disturb it.
// [R19] Loads address bytes; the byte select bit picks low or high byte.
// [R20] Stores executed from the application section are ignored.
// [R21] Execution section is found by comparing PC with loader start.
`include "fbl_defs.svh"
`default_nettype none
module fbl_top
   import fbl_pkg::*;
#(
   parameter bit HAS_EXT = 1'b1
)
(
   input wire logic clk,
   input wire logic rst,
   input wire fbl_pkg::fbl_op_t op,
   input wire logic [`FBL_WADDR_W-1:0] pc_word,
   input wire logic ext_we,
   input wire logic [7:0] ext_wdata,
   input wire logic [7:0] ptr_high,
   input wire logic [7:0] ptr_low,
   input wire logic [5:0] guard_wdata,
   input wire logic chip_erase,
   input wire logic prog_if_we,
   input wire logic [5:0] prog_if_guard,
   input wire logic reset_vector_select_fuse,
   input wire logic [`FBL_WADDR_W-1:0] boot_start,
   input wire logic ivt_in_loader,
   input wire logic [15:0] flash_rdata,
   input wire logic prog_done,
   output logic [7:0] ext_rdata,
   output logic [`FBL_PTR_W-1:0] flash_pointer,
   output logic [`FBL_WADDR_W-1:0] reset_vector,
   output logic flash_rd,
   output logic [`FBL_WADDR_W-1:0] flash_raddr,
   output logic [7:0] load_data,
   output logic load_valid,
   output logic load_refused,
   output logic prog_start,
   output logic prog_busy,
   output logic [`FBL_WADDR_W-`FBL_PAGE_WORD_BITS-1:0] prog_page,
   output logic [`FBL_PAGE_WORD_BITS-1:0] prog_word,
   output logic store_refused,
   output logic irq_allow,
   output logic [5:0] guard_rdata
);
   import fbl_pkg::*;

   typedef enum logic [1:0] {
      FBL_IDLE,
      FBL_READ,
      FBL_PROG
   } fbl_state_t;

   fbl_state_t state_q, state_d;
   logic [7:0] ext_q, ext_d;
   fbl_guard_t app_guard_q, app_guard_d;
   fbl_guard_t loader_guard_q, loader_guard_d;
   logic [`FBL_PTR_W-1:0] ptr_q, ptr_d;
   logic [`FBL_WADDR_W-1:0] raddr_q, raddr_d;
   logic byte_sel_q, byte_sel_d;
   logic [`FBL_WADDR_W-1:0] latch_q, latch_d;
   logic [`FBL_WADDR_W-1:0] rvec_q, rvec_d;
   logic rvec_done_q, rvec_done_d;
   logic rd_q, rd_d;
   logic [7:0] ldata_q, ldata_d;
   logic lvalid_q, lvalid_d;
   logic lref_q, lref_d;
   logic pstart_q, pstart_d;
   logic sref_q, sref_d;
   logic irq_q, irq_d;
   logic [`FBL_PTR_W-1:0] cur_ptr;
   logic [`FBL_WADDR_W-1:0] cur_word;
   logic exec_in_loader, target_in_loader, store_ok, load_ok, irq_ok;

   always_comb begin
      cur_ptr = {ext_q, ptr_high, ptr_low}; // see [R14]
      cur_word = cur_ptr[`FBL_PTR_W-1:1];
   end

   fbl_guard_check u_check (
      .pc_word(pc_word),
      .target_word(cur_word),
      .boot_start(boot_start),
      .app_guard(app_guard_q),
      .loader_guard(loader_guard_q),
      .ivt_in_loader(ivt_in_loader),
      .exec_in_loader(exec_in_loader),
      .target_in_loader(target_in_loader),
      .store_ok(store_ok),
      .load_ok(load_ok),
      .irq_ok(irq_ok)
   );

   // Guard fields: software and programming port may only clear bits.
   always_comb begin
      app_guard_d = app_guard_q;
      loader_guard_d = loader_guard_q;
      if (chip_erase) begin
         app_guard_d = `FBL_GUARD_OPEN; // see [R2]
         loader_guard_d = `FBL_GUARD_OPEN;
      end else begin
         if (prog_if_we) begin
            app_guard_d = app_guard_d & prog_if_guard[3:2]; // see [R1]
            loader_guard_d = loader_guard_d & prog_if_guard[5:4];
         end
         if (op == FBL_OP_GUARD_SET && exec_in_loader) begin
            app_guard_d = app_guard_d & guard_wdata[3:2]; // see [R2]
            loader_guard_d = loader_guard_d & guard_wdata[5:4];
         end
      end
   end

   always_ff @(posedge clk) begin
      // Guards are nonvolatile in the array, so reset does not open them.
      if (rst && chip_erase) begin
         app_guard_q <= `FBL_GUARD_OPEN;
         loader_guard_q <= `FBL_GUARD_OPEN;
      end else begin
         app_guard_q <= app_guard_d;
         loader_guard_q <= loader_guard_d;
      end
   end

   // Extension register; tied to zero in small variants.
   always_comb begin
      ext_d = ext_q;
      if (ext_we && HAS_EXT) begin
         ext_d = ext_wdata; // see [R15]
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ext_q <= `FBL_EXT_RST;
      end else begin
         ext_q <= ext_d;
      end
   end

   // Reset vector is caught once after reset release, from the fuse input.
   // The fuse has no write path here at all.
   always_comb begin
      rvec_d = rvec_q;
      rvec_done_d = rvec_done_q;
      if (!rvec_done_q) begin
         rvec_d = reset_vector_select_fuse ? `FBL_APP_RESET_ADDR
                                           : boot_start; // see [R12] see [R13]
         rvec_done_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rvec_q <= `FBL_APP_RESET_ADDR;
         rvec_done_q <= 1'b0;
      end else begin
         rvec_q <= rvec_d;
         rvec_done_q <= rvec_done_d;
      end
   end

   // Access sequencing.
   always_comb begin
      state_d = state_q;
      ptr_d = ptr_q;
      raddr_d = raddr_q;
      byte_sel_d = byte_sel_q;
      latch_d = latch_q;
      rd_d = 1'b0;
      ldata_d = ldata_q;
      lvalid_d = 1'b0;
      lref_d = 1'b0;
      pstart_d = 1'b0;
      sref_d = 1'b0;
      irq_d = irq_ok;
      case (state_q)
         FBL_IDLE: begin
            ptr_d = cur_ptr;
            if (op == FBL_OP_LOAD) begin
               if (load_ok) begin
                  raddr_d = cur_word;
                  byte_sel_d = cur_ptr[0]; // see [R19]
                  rd_d = 1'b1;
                  state_d = FBL_READ;
               end else begin
                  lref_d = 1'b1; // see [R7] see [R10]
                  ldata_d = 8'h00;
               end
            end else if (op == FBL_OP_STORE) begin
               if (store_ok) begin
                  latch_d = cur_word; // see [R18]
                  pstart_d = 1'b1;
                  state_d = FBL_PROG;
               end else begin
                  sref_d = 1'b1; // see [R20]
               end
            end
         end
         FBL_READ: begin
            ldata_d = byte_sel_q ? flash_rdata[15:8]
                                 : flash_rdata[7:0]; // see [R19]
            lvalid_d = 1'b1;
            state_d = FBL_IDLE;
         end
         FBL_PROG: begin
            // Further requests are ignored; the latched address stays put.
            if (prog_done) begin
               state_d = FBL_IDLE;
            end
         end
         default: begin
            state_d = FBL_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= FBL_IDLE;
         ptr_q <= '0;
         raddr_q <= '0;
         byte_sel_q <= 1'b0;
         latch_q <= '0;
         rd_q <= 1'b0;
         ldata_q <= 8'h00;
         lvalid_q <= 1'b0;
         lref_q <= 1'b0;
         pstart_q <= 1'b0;
         sref_q <= 1'b0;
         irq_q <= 1'b1;
      end else begin
         state_q <= state_d;
         ptr_q <= ptr_d;
         raddr_q <= raddr_d;
         byte_sel_q <= byte_sel_d;
         latch_q <= latch_d;
         rd_q <= rd_d;
         ldata_q <= ldata_d;
         lvalid_q <= lvalid_d;
         lref_q <= lref_d;
         pstart_q <= pstart_d;
         sref_q <= sref_d;
         irq_q <= irq_d;
      end
   end

   // General lock bits are deliberately not inputs here. see [R3] see [R4]
   always_comb begin
      ext_rdata = ext_q;
      flash_pointer = ptr_q;
      reset_vector = rvec_q;
      flash_rd = rd_q;
      flash_raddr = raddr_q;
      load_data = ldata_q;
      load_valid = lvalid_q;
      load_refused = lref_q;
      prog_start = pstart_q;
      prog_busy = (state_q == FBL_PROG);
      prog_page = latch_q[`FBL_WADDR_W-1:`FBL_PAGE_WORD_BITS]; // see [R16]
      prog_word = latch_q[`FBL_PAGE_WORD_BITS-1:0];
      store_refused = sref_q;
      irq_allow = irq_q;
      guard_rdata = {loader_guard_q, app_guard_q, 2'h3};
   end
endmodule
`default_nettype wire

// file: tb/fbl_top_properties.sv
// Port-level assertions for the flash boot lock block.
`include "fbl_defs.svh"
`default_nettype none
module fbl_top_properties (
   input wire logic clk,
   input wire logic rst,
   input wire fbl_pkg::fbl_op_t op,
   input wire logic [`FBL_WADDR_W-1:0] pc_word,
   input wire logic [`FBL_WADDR_W-1:0] boot_start,
   input wire logic reset_vector_select_fuse,
   input wire logic ivt_in_loader,
   input wire logic chip_erase,
   input wire logic prog_done,
   input wire logic [`FBL_PTR_W-1:0] flash_pointer,
   input wire logic [`FBL_WADDR_W-1:0] reset_vector,
   input wire logic flash_rd,
   input wire logic load_valid,
   input wire logic load_refused,
   input wire logic prog_start,
   input wire logic prog_busy,
   input wire logic [15:0] prog_page,
   input wire logic [6:0] prog_word,
   input wire logic store_refused,
   input wire logic irq_allow,
   input wire logic [5:0] guard_rdata
);
   import fbl_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic xl, tl, sok, lok, iok;
   assign xl = pc_word >= boot_start;
   assign tl = flash_pointer[23:1] >= boot_start;
   assign sok = xl && (tl ? guard_rdata[4] : guard_rdata[2]);
   assign lok = (xl == tl) || (tl ? guard_rdata[5] : guard_rdata[3]);
   assign iok = !(!xl && !guard_rdata[3] && ivt_in_loader)
      && !(xl && !guard_rdata[5] && !ivt_in_loader);
   sequence load_ans;
      ##1 flash_rd ##1 load_valid;
   endsequence
   sequence store_ans;
      ##1 prog_start && prog_busy;
   endsequence
   store_gate_a: assert property (op == FBL_OP_STORE && !prog_busy |->
      if (sok) store_ans else ##1 store_refused) else $error("store gate");
   load_gate_a: assert property (op == FBL_OP_LOAD && !prog_busy |->
      if (lok) load_ans else ##1 load_refused) else $error("load gate");
   irq_gate_a: assert property ($stable(guard_rdata) ##1 $stable(guard_rdata)
      |-> irq_allow == $past(iok)) else $error("irq gate");
   rst_vec_a: assert property ($fell(rst) |-> ##1 reset_vector ==
      (reset_vector_select_fuse ? `FBL_APP_RESET_ADDR : boot_start))
      else $error("reset vector");
   page_split_a: assert property (prog_start |->
      {prog_page, prog_word} == flash_pointer[23:1]) else $error("page split");
   ptr_hold_a: assert property (prog_busy && $past(prog_busy) |->
      $stable(flash_pointer)) else $error("pointer moved");
   busy_end_a: assert property (prog_busy && prog_done |=> !prog_busy)
      else $error("busy stuck");
   guard_mono_a: assert property (!chip_erase && !$past(chip_erase) &&
      !$past(chip_erase, 2) && !$past(rst, 2) |=>
      (guard_rdata & ~$past(guard_rdata)) == 6'h00) else $error("guard rose");
endmodule
bind fbl_top fbl_top_properties fbl_top_properties_inst (.*);
`default_nettype wire

// file: tb/fbl_flash_model.sv
// Flash array stand-in: answers word reads and ends programming.
`include "fbl_defs.svh"
`default_nettype none
module fbl_flash_model (
   input wire logic clk,
   input wire logic flash_rd,
   input wire logic [`FBL_WADDR_W-1:0] flash_raddr,
   input wire logic prog_start,
   input wire logic [7:0] prog_delay,
   output logic [15:0] flash_rdata,
   output logic prog_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rd_q = 1'b0;
   logic [15:0] junk_q = 16'h5A5A;
   logic [7:0] cnt_q = 8'h00;
   // Outside the read window the data lines churn, so stale data never passes.
   assign flash_rdata = (flash_rd || rd_q) ?
      {flash_raddr[7:0] ^ 8'hA5, flash_raddr[7:0]} : junk_q;
   assign prog_done = cnt_q == 8'h01;
   always @(posedge clk) begin
      rd_q <= flash_rd;
      junk_q <= junk_q + 16'h3C3D;
      if (prog_start)
         cnt_q <= prog_delay;
      else if (cnt_q != 8'h00)
         cnt_q <= cnt_q - 8'h01;
   end
endmodule
`default_nettype wire

// file: tb/fbl_top_tb.sv
// Self-checking bench for the flash boot lock block.
`include "fbl_defs.svh"
`default_nettype none
module fbl_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import fbl_pkg::*;
   logic clk = 1'b0, rst = 1'b1, chip_erase = 1'b1, ext_we = 1'b0;
   logic prog_if_we = 1'b0, reset_vector_select_fuse = 1'b1;
   logic ivt_in_loader = 1'b0;
   logic flash_rd, load_valid, load_refused, prog_start, prog_busy;
   logic store_refused, irq_allow, prog_done;
   fbl_op_t op = FBL_OP_NONE;
   logic [7:0] ext_wdata = 8'h00, ptr_high = 8'h00, ptr_low = 8'h00;
   logic [7:0] dly = 8'h01, ext_rdata, load_data;
   logic [5:0] guard_wdata = 6'h3F, prog_if_guard = 6'h3F, gd, guard_rdata;
   logic [22:0] boot_start = `FBL_BOOT_START_DEF;
   logic [22:0] lpc = `FBL_BOOT_START_DEF + 23'h000005;
   logic [22:0] pc_word = 23'h000000, reset_vector, flash_raddr;
   logic [23:0] flash_pointer;
   logic [15:0] flash_rdata, prog_page;
   logic [6:0] prog_word;
   logic [31:0] rnd = 32'h0000003B, exp_q[$];
   int mismatches = 0, comparisons = 0;
   always #2.5 clk = ~clk;
   fbl_top fbl_top_inst (.*);
   fbl_flash_model fbl_flash_model_inst (.clk(clk), .flash_rd(flash_rd),
      .flash_raddr(flash_raddr), .prog_start(prog_start), .prog_delay(dly),
      .flash_rdata(flash_rdata), .prog_done(prog_done));
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic check(input string what, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic guards(input logic [1:0] a, l);
      @(negedge clk);
      chip_erase = 1'b1;
      @(negedge clk);
      chip_erase = 1'b0;
      guard_wdata = {l, a, 2'b11};
      pc_word = lpc;
      op = FBL_OP_GUARD_SET;
      @(negedge clk);
      op = FBL_OP_NONE;
      gd = {l, a, 2'b11};
      repeat (2) @(negedge clk);
      check("guards", {26'h0, guard_rdata}, {26'h0, gd});
   endtask
   task automatic access(input fbl_op_t k, input logic [22:0] pc,
      input logic [23:0] p);
      logic [22:0] w;
      logic xl, tl, ok;
      w = p[23:1];
      xl = pc >= boot_start;
      tl = w >= boot_start;
      @(negedge clk);
      ext_we = 1'b1;
      {ext_wdata, ptr_high, ptr_low} = p;
      pc_word = pc;
      @(negedge clk);
      ext_we = 1'b0;
      repeat (2) @(negedge clk);
      if (k == FBL_OP_LOAD) begin
         ok = (xl == tl) || (tl ? gd[5] : gd[3]);
         exp_q.push_back(ok ? {4'h8, 20'h0, p[0] ? w[7:0] ^ 8'hA5 : w[7:0]}
            : 32'h40000000);
      end else begin
         ok = xl && (tl ? gd[4] : gd[2]);
         exp_q.push_back(ok ? {4'h2, 5'h0, w} : 32'h10000000);
      end
      op = k;
      @(negedge clk);
      op = FBL_OP_NONE;
      // Moving the pointer mid-programming must not disturb the latched page.
      ptr_high = ~ptr_high;
      for (int i = 0; i < 40 && prog_busy !== 1'b0; i++)
         @(negedge clk);
      repeat (3) @(negedge clk);
   endtask
   always @(negedge clk) begin
      if (load_valid | load_refused | prog_start | store_refused) begin
         if (exp_q.size() == 0)
            check("spare answer", 32'h1, 32'h0);
         else
            check("answer", {load_valid, load_refused, prog_start,
               store_refused, prog_start ? {5'h0, prog_page, prog_word} :
               store_refused ? 28'h0 : {20'h0, load_data}},
               exp_q.pop_front());
      end
   end
   initial begin
      #50000;
      mismatches++;
      report_and_stop();
   end
   initial begin
      repeat (12) @(negedge clk);
      rst = 1'b0;
      chip_erase = 1'b0;
      repeat (3) @(negedge clk);
      check("reset vector", {9'h0, reset_vector}, 32'h0);
      check("extension", {24'h0, ext_rdata}, 32'h0);
      prog_if_we = 1'b1;
      prog_if_guard = 6'h3B;
      @(negedge clk);
      prog_if_we = 1'b0;
      guard_wdata = 6'h3F;
      pc_word = 23'h000100;
      op = FBL_OP_GUARD_SET;
      @(negedge clk);
      op = FBL_OP_NONE;
      repeat (2) @(negedge clk);
      check("interface guard", {26'h0, guard_rdata}, 32'h3B);
      $display("Reset and guard interface test done");
      for (int m = 0; m < 16; m++) begin
         guards(m[1:0], m[3:2]);
         ivt_in_loader = m[0];
         dly = {4'h0, m[3:0]} + 8'h01;
         rnd = xs(rnd);
         access(FBL_OP_STORE, lpc, {8'h00, rnd[15:0]});
         access(FBL_OP_STORE, lpc, {8'hFE, rnd[31:16]});
         access(FBL_OP_STORE, 23'h000100, {8'h00, rnd[15:0]});
         access(FBL_OP_LOAD, lpc, {8'h00, rnd[15:0]});
         access(FBL_OP_LOAD, 23'h000100, {8'hFE, rnd[31:16]});
         access(FBL_OP_LOAD, 23'h000100, {8'h00, rnd[23:8]});
         $display("Guard pair %0d done", m);
      end
      check("pending answers", exp_q.size(), 32'h0);
      rst = 1'b1;
      chip_erase = 1'b1;
      reset_vector_select_fuse = 1'b0;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      chip_erase = 1'b0;
      repeat (3) @(negedge clk);
      check("loader vector", {9'h0, reset_vector}, {9'h0, boot_start});
      $display("Second reset test done");
      report_and_stop();
   end
endmodule
`default_nettype wire
